// [sarrd_defs.svh]
// timing counts, widths and field sizes shared by both ends of the readout link
// assumes both ends run their own clock at the rate given by SARRD_MCLK_NS
`ifndef SARRD_DEFS_SVH
`define SARRD_DEFS_SVH

// own clock period
`define SARRD_MCLK_NS         8
// conversion window, acquisition, spacing and start-line low time
`define SARRD_TCONV_MIN_NS    500
`define SARRD_TCONV_MAX_NS    8800
`define SARRD_TACQ_NS         1200
`define SARRD_TSPACE_NS       1000
`define SARRD_TCNV_LOW_NS     20
// least times, rounded up to whole cycles
`define SARRD_TCONV_MIN_CYC   ((`SARRD_TCONV_MIN_NS + `SARRD_MCLK_NS - 1) / `SARRD_MCLK_NS)
`define SARRD_TCONV_MAX_CYC   ((`SARRD_TCONV_MAX_NS + `SARRD_MCLK_NS - 1) / `SARRD_MCLK_NS)
`define SARRD_TACQ_CYC        ((`SARRD_TACQ_NS + `SARRD_MCLK_NS - 1) / `SARRD_MCLK_NS)
`define SARRD_TSPACE_CYC      ((`SARRD_TSPACE_NS + `SARRD_MCLK_NS - 1) / `SARRD_MCLK_NS)
`define SARRD_TCNV_LOW_CYC    ((`SARRD_TCNV_LOW_NS + `SARRD_MCLK_NS - 1) / `SARRD_MCLK_NS)
// result word and serial frame
`define SARRD_RES_W           16
`define SARRD_FRAME_BITS      16
`define SARRD_BITCNT_W        5
`define SARRD_BITCNT_MAX      5'h1F
// one approximation step per this many cycles: 16 x 4 = 64 cycles = 512 ns
`define SARRD_SAR_STEP_CYC    4
// host serial clock half period in own cycles
`define SARRD_SCLK_HALF_CYC   8
// host timer width and result buffer depth
`define SARRD_HTMR_W          11
`define SARRD_FIFO_DEPTH      2

`endif

// [sarrd_pkg.sv]
// types shared by both ends of the converter readout link
// assumes sarrd_defs.svh is on the include path
`default_nettype none
`include "sarrd_defs.svh"

package sarrd_pkg;
	typedef logic [`SARRD_RES_W-1:0] sarrd_word_t;

	// converter phase
	typedef enum logic [0:0] {
		SARRD_ACQ  = 1'b0,
		SARRD_CONV = 1'b1
	} sarrd_dev_st_e;

	// host sequencer
	typedef enum logic [2:0] {
		SARRD_H_IDLE  = 3'b000,
		SARRD_H_CONV  = 3'b001,
		SARRD_H_SETUP = 3'b010,
		SARRD_H_HIGH  = 3'b011,
		SARRD_H_LOW   = 3'b100,
		SARRD_H_END   = 3'b101
	} sarrd_host_st_e;
endpackage

`default_nettype wire

// [sarrd_if.sv]
// pins between the converter and its host controller
// assumes a pull-up on the serial output wire while nobody drives it
`timescale 1ns/10ps
`default_nettype none

interface sarrd_if;
	logic conversionStartLine;
	logic selectSerialIn;
	logic serialClock;
	logic serialOut;
	logic serialOutOe;
	logic serialOutLine;

	// wire level: pulled high when released
	assign serialOutLine = serialOutOe ? serialOut : 1'b1;

	modport device (
		input  conversionStartLine,
		input  selectSerialIn,
		input  serialClock,
		output serialOut,
		output serialOutOe
	);

	modport host (
		output conversionStartLine,
		output selectSerialIn,
		output serialClock,
		input  serialOutLine
	);
endinterface

`default_nettype wire

// [sarrd_adc_end.sv]
// converter end: sequencing and result shift-out on the internal oscillator, edge count and chain capture on the serial clock
// assumes mclk stands for the internal oscillator and the serial clock idles between frames
//
// Operation
// - conversion timed internally, 500 to 8800 ns
// - host reads only during acquisition
// - serial clock only shifts result data
// - sample inputs, disconnect during conversion
// - reconnect, power down, result readable
// - host keeps acquisition and start spacing
// - select low drives result msb out
// - release output on select high, last fall
// - host: select high at start selects select-mode
// - host: select low at start selects daisy
// - host: serial clock stable around start
// - daisy: capture serial-in on falling edges
// - host: start line low at least 20 ns
// - latch interface mode at start edge
// - tri-state at 16th fall or select high
// - next bits on successive falling edges
// - result is unsigned straight binary
`timescale 1ns/10ps
`default_nettype none
`include "sarrd_defs.svh"

module sarrd_adc_end
	import sarrd_pkg::*;
(
	// internal oscillator and reset
	input  wire logic                    mclk,
	input  wire logic                    arst_n,
	// link pins
	sarrd_if.device                      lnk,
	// analog inputs, modelled as level words
	input  wire logic [`SARRD_RES_W-1:0] positiveAnalogInput,
	input  wire logic [`SARRD_RES_W-1:0] negativeAnalogInput,
	// status
	output logic                         converting,
	output logic                         inputsConnected,
	output logic                         poweredDown,
	output logic                         daisyMode,
	output logic [`SARRD_RES_W-1:0]      lastResult
);

	localparam int SYNC_W = 2 + 2 * `SARRD_RES_W;

	// gray code to binary for the crossed bit count
	function automatic logic [`SARRD_BITCNT_W-1:0] gray2bin(
		input logic [`SARRD_BITCNT_W-1:0] g
	);
		logic [`SARRD_BITCNT_W-1:0] b;
		b[`SARRD_BITCNT_W-1] = g[`SARRD_BITCNT_W-1];
		for (int i = `SARRD_BITCNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers into the oscillator domain

	logic [SYNC_W-1:0]          syncAFf;
	logic [SYNC_W-1:0]          syncBFf;
	logic [`SARRD_BITCNT_W-1:0] grayAFf;
	logic [`SARRD_BITCNT_W-1:0] grayBFf;
	logic [`SARRD_BITCNT_W-1:0] bitGrayFf;
	logic                       cnvS;
	logic                       dinS;
	logic [`SARRD_RES_W-1:0]    posS;
	logic [`SARRD_RES_W-1:0]    negS;
	logic [`SARRD_BITCNT_W-1:0] cntBin;

	// two stages each; the inputs word is static around the start edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncAFf <= '0;
			syncBFf <= '0;
			grayAFf <= '0;
			grayBFf <= '0;
		end else begin
			syncAFf <= {lnk.conversionStartLine, lnk.selectSerialIn,
			            positiveAnalogInput, negativeAnalogInput};
			syncBFf <= syncAFf;
			grayAFf <= bitGrayFf;
			grayBFf <= grayAFf;
		end
	end

	assign cnvS   = syncBFf[SYNC_W-1];
	assign dinS   = syncBFf[SYNC_W-2];
	assign posS   = syncBFf[2*`SARRD_RES_W-1:`SARRD_RES_W];
	assign negS   = syncBFf[`SARRD_RES_W-1:0];
	assign cntBin = gray2bin(grayBFf);

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer and output drive

	sarrd_dev_st_e           stFf;
	sarrd_dev_st_e           nxt_st;
	logic                    cnvPrevFf;
	logic                    nxt_cnvPrev;
	logic                    modeDaisyFf;
	logic                    nxt_modeDaisy;
	sarrd_word_t             sampleFf;
	sarrd_word_t             nxt_sample;
	sarrd_word_t             approxFf;
	sarrd_word_t             nxt_approx;
	sarrd_word_t             resultFf;
	sarrd_word_t             nxt_result;
	logic [3:0]              stepFf;
	logic [3:0]              nxt_step;
	logic [1:0]              phaseFf;
	logic [1:0]              nxt_phase;
	logic                    connFf;
	logic                    nxt_conn;
	logic                    pdFf;
	logic                    nxt_pd;
	logic                    convFf;
	logic                    nxt_conv;
	logic                    runFf;
	logic                    nxt_run;
	logic                    sdoFf;
	logic                    nxt_sdo;
	logic                    oeFf;
	logic                    nxt_oe;
	logic [`SARRD_RES_W-1:0] chainFf;
	sarrd_word_t             trial;
	sarrd_word_t             kept;

	// next state of the sequencer and of the pin drive
	always_comb begin
		nxt_st        = stFf;
		nxt_cnvPrev   = cnvS;
		nxt_modeDaisy = modeDaisyFf;
		nxt_sample    = sampleFf;
		nxt_approx    = approxFf;
		nxt_result    = resultFf;
		nxt_step      = stepFf;
		nxt_phase     = phaseFf;
		nxt_conn      = connFf;
		nxt_pd        = pdFf;
		trial         = approxFf | (16'h0001 << stepFf);
		kept          = (trial <= sampleFf) ? trial : approxFf;
		unique case (stFf)
			SARRD_ACQ: begin
				if (cnvS && !cnvPrevFf) begin
					nxt_modeDaisy = ~dinS;
					nxt_sample = (posS >= negS) ? (posS - negS) : 16'h0000;
					nxt_approx = 16'h0000;
					nxt_step   = 4'hF;
					nxt_phase  = 2'h0;
					nxt_conn   = 1'b0;
					nxt_pd     = 1'b0;
					nxt_st     = SARRD_CONV;
				end
			end
			SARRD_CONV: begin
				nxt_phase = phaseFf + 2'h1;
				if (phaseFf == 2'(`SARRD_SAR_STEP_CYC - 1)) begin
					nxt_approx = kept;
					nxt_step   = stepFf - 4'h1;
					if (stepFf == 4'h0) begin
						nxt_result = kept;
						nxt_conn   = 1'b1;
						nxt_pd     = 1'b1;
						nxt_st     = SARRD_ACQ;
					end
				end
			end
		endcase
		nxt_conv = (nxt_st == SARRD_CONV);
		// read window only in acquisition; select-mode also needs select low
		// select low opens readout
		nxt_run = (stFf == SARRD_ACQ) && cnvS && (modeDaisyFf || !dinS);
		// daisy output drives always, low outside the read window
		if (modeDaisyFf) begin
			nxt_oe  = 1'b1;
			nxt_sdo = !runFf ? 1'b0 :
			          cntBin[4] ? chainFf[cntBin[3:0]] : resultFf[~cntBin[3:0]];
		end else begin
			nxt_oe  = runFf && !dinS && !cntBin[4];
			// bit per falling edge, msb first
			nxt_sdo = nxt_oe ? resultFf[~cntBin[3:0]] : 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stFf        <= SARRD_ACQ;
			cnvPrevFf   <= 1'b0;
			modeDaisyFf <= 1'b0;
			sampleFf    <= 16'h0000;
			approxFf    <= 16'h0000;
			resultFf    <= 16'h0000;
			stepFf      <= 4'h0;
			phaseFf     <= 2'h0;
			connFf      <= 1'b1;
			pdFf        <= 1'b1;
			convFf      <= 1'b0;
			runFf       <= 1'b0;
			sdoFf       <= 1'b0;
			oeFf        <= 1'b0;
		end else begin
			stFf        <= nxt_st;
			cnvPrevFf   <= nxt_cnvPrev;
			modeDaisyFf <= nxt_modeDaisy;
			sampleFf    <= nxt_sample;
			approxFf    <= nxt_approx;
			resultFf    <= nxt_result;
			stepFf      <= nxt_step;
			phaseFf     <= nxt_phase;
			connFf      <= nxt_conn;
			pdFf        <= nxt_pd;
			convFf      <= nxt_conv;
			runFf       <= nxt_run;
			sdoFf       <= nxt_sdo;
			oeFf        <= nxt_oe;
		end
	end

	assign lnk.serialOut    = sdoFf;
	assign lnk.serialOutOe  = oeFf;
	assign converting       = convFf;
	assign inputsConnected  = connFf;
	assign poweredDown      = pdFf;
	assign daisyMode        = modeDaisyFf;
	assign lastResult       = resultFf;

	////////////////////////////////////////////////////////////////////////////////
	// serial clock domain: falling-edge count and chain capture

	logic                       linkRstN;
	logic [`SARRD_BITCNT_W-1:0] bitCntFf;
	logic [`SARRD_BITCNT_W-1:0] nxt_bitCnt;
	logic [`SARRD_BITCNT_W-1:0] nxt_bitGray;
	logic [`SARRD_RES_W-1:0]    nxt_chain;

	// held cleared outside the read window; the clock is still then, so the
	// release never meets an edge
	assign linkRstN = arst_n & runFf;

	// count saturates at 31 so a two-device chain is the deepest supported
	always_comb begin
		nxt_bitCnt  = (bitCntFf == `SARRD_BITCNT_MAX) ? bitCntFf : bitCntFf + 5'h01;
		nxt_bitGray = nxt_bitCnt ^ (nxt_bitCnt >> 1);
		nxt_chain   = chainFf;
		if (!bitCntFf[4]) begin
			nxt_chain[bitCntFf[3:0]] = lnk.selectSerialIn;
		end
	end

	// chain entries are read only once the crossed count says they are written
	always_ff @(negedge lnk.serialClock or negedge linkRstN) begin
		if (!linkRstN) begin
			bitCntFf  <= '0;
			bitGrayFf <= '0;
			chainFf   <= 16'h0000;
		end else begin
			bitCntFf  <= nxt_bitCnt;
			bitGrayFf <= nxt_bitGray;
			chainFf   <= nxt_chain;
		end
	end

endmodule // sarrd_adc_end

`default_nettype wire

// [sarrd_host_end.sv]
// host end: starts conversions, waits them out, clocks the result in, buffers words
// assumes the converter end on the other side of sarrd_if and a user that may stall
`timescale 1ns/10ps
`default_nettype none
`include "sarrd_defs.svh"

module sarrd_host_end
	import sarrd_pkg::*;
(
	// own clock and reset
	input  wire logic                    mclk,
	input  wire logic                    arst_n,
	// link pins
	sarrd_if.host                        lnk,
	// control
	input  wire logic                    runEn,
	input  wire logic                    daisySel,
	output logic                         busy,
	// result stream
	output logic                         outValid,
	input  wire logic                    outReady,
	output logic [`SARRD_RES_W-1:0]      outData
);

	localparam logic [`SARRD_HTMR_W-1:0] ACQ_END  = `SARRD_HTMR_W'(`SARRD_TACQ_CYC - 1);
	localparam logic [`SARRD_HTMR_W-1:0] CONV_END = `SARRD_HTMR_W'(`SARRD_TCONV_MAX_CYC - 1);
	localparam logic [`SARRD_HTMR_W-1:0] HALF_END = `SARRD_HTMR_W'(`SARRD_SCLK_HALF_CYC - 1);
	localparam logic [1:0]               DEPTH    = 2'(`SARRD_FIFO_DEPTH);

	////////////////////////////////////////////////////////////////////////////////
	// serial output synchroniser

	logic sdoAFf;
	logic sdoBFf;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sdoAFf <= 1'b1;
			sdoBFf <= 1'b1;
		end else begin
			sdoAFf <= lnk.serialOutLine;
			sdoBFf <= sdoAFf;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	sarrd_host_st_e            stFf;
	sarrd_host_st_e            nxt_st;
	logic [`SARRD_HTMR_W-1:0]  tmrFf;
	logic [`SARRD_HTMR_W-1:0]  nxt_tmr;
	logic [3:0]                bitFf;
	logic [3:0]                nxt_bit;
	sarrd_word_t               shFf;
	sarrd_word_t               nxt_sh;
	logic                      modeFf;
	logic                      nxt_mode;
	logic                      cnvFf;
	logic                      nxt_cnv;
	logic                      dinFf;
	logic                      nxt_din;
	logic                      sclkFf;
	logic                      nxt_sclk;
	logic                      busyFf;
	logic                      nxt_busy;
	logic                      push;
	logic                      inReady;
	logic [1:0]                cntFf;

	// a start waits for buffer room, so a stalled user stops conversions
	assign inReady = (cntFf < DEPTH);

	always_comb begin
		nxt_st   = stFf;
		nxt_tmr  = tmrFf + 11'h001;
		nxt_bit  = bitFf;
		nxt_sh   = shFf;
		nxt_mode = modeFf;
		nxt_cnv  = cnvFf;
		nxt_din  = dinFf;
		nxt_sclk = sclkFf;
		push     = 1'b0;
		unique case (stFf)
			SARRD_H_IDLE: begin
				// idle span covers start-line low, acquisition and start spacing
				// start line low long enough
				if (tmrFf == 11'h000) begin
					nxt_mode = daisySel;
					nxt_din  = ~daisySel;
				end
				if (tmrFf >= ACQ_END) begin
					nxt_tmr = tmrFf;
					if (runEn && inReady) begin
						nxt_cnv = 1'b1;
						nxt_tmr = 11'h000;
						nxt_st  = SARRD_H_CONV;
					end
				end
			end
			SARRD_H_CONV: begin
				if (tmrFf == CONV_END) begin
					nxt_din = modeFf ? dinFf : 1'b0;
					nxt_tmr = 11'h000;
					nxt_st  = SARRD_H_SETUP;
				end
			end
			SARRD_H_SETUP, SARRD_H_LOW: begin
				if (tmrFf == HALF_END) begin
					nxt_sclk = 1'b1;
					nxt_tmr  = 11'h000;
					nxt_st   = SARRD_H_HIGH;
				end
			end
			SARRD_H_HIGH: begin
				// sample late in the high phase, then make the falling edge
				if (tmrFf == HALF_END) begin
					nxt_sh   = {shFf[`SARRD_RES_W-2:0], sdoBFf};
					nxt_sclk = 1'b0;
					nxt_tmr  = 11'h000;
					nxt_bit  = bitFf + 4'h1;
					nxt_st   = (bitFf == 4'hF) ? SARRD_H_END : SARRD_H_LOW;
				end
			end
			SARRD_H_END: begin
				if (tmrFf == HALF_END) begin
					push    = 1'b1;
					nxt_din = ~modeFf;
					nxt_cnv = 1'b0;
					nxt_tmr = 11'h000;
					nxt_st  = SARRD_H_IDLE;
				end
			end
			default: begin
				nxt_st = SARRD_H_IDLE;
			end
		endcase
		nxt_busy = (nxt_st != SARRD_H_IDLE);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stFf   <= SARRD_H_IDLE;
			tmrFf  <= 11'h000;
			bitFf  <= 4'h0;
			shFf   <= 16'h0000;
			modeFf <= 1'b0;
			cnvFf  <= 1'b0;
			dinFf  <= 1'b1;
			sclkFf <= 1'b0;
			busyFf <= 1'b0;
		end else begin
			stFf   <= nxt_st;
			tmrFf  <= nxt_tmr;
			bitFf  <= nxt_bit;
			shFf   <= nxt_sh;
			modeFf <= nxt_mode;
			cnvFf  <= nxt_cnv;
			dinFf  <= nxt_din;
			sclkFf <= nxt_sclk;
			busyFf <= nxt_busy;
		end
	end

	assign lnk.conversionStartLine = cnvFf;
	assign lnk.selectSerialIn      = dinFf;
	assign lnk.serialClock         = sclkFf;
	assign busy                    = busyFf;

	////////////////////////////////////////////////////////////////////////////////
	// two-entry result buffer; head entry drives the user port directly

	sarrd_word_t memFf [`SARRD_FIFO_DEPTH];
	sarrd_word_t nxt_mem [`SARRD_FIFO_DEPTH];
	logic [1:0]  nxt_cnt;
	logic        validFf;
	logic        pop;

	always_comb begin
		pop        = validFf && outReady;
		nxt_mem[0] = memFf[0];
		nxt_mem[1] = memFf[1];
		if (pop) begin
			nxt_mem[0] = memFf[1];
		end
		if (push) begin
			if ((cntFf == 2'h0) || ((cntFf == 2'h1) && pop)) begin
				nxt_mem[0] = shFf;
			end else begin
				nxt_mem[1] = shFf;
			end
		end
		nxt_cnt = cntFf + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			memFf[0] <= 16'h0000;
			memFf[1] <= 16'h0000;
			cntFf    <= 2'h0;
			validFf  <= 1'b0;
		end else begin
			memFf[0] <= nxt_mem[0];
			memFf[1] <= nxt_mem[1];
			cntFf    <= nxt_cnt;
			validFf  <= (nxt_cnt != 2'h0);
		end
	end

	assign outValid = validFf;
	assign outData  = memFf[0];

endmodule // sarrd_host_end

`default_nettype wire

// [sarrd_host_end_dummy_never.sv]
`timescale 1ns/10ps

// [sarrd_properties.sv]
// assertions on the converter link pins, fed with the interface signals
// assumes both ends and this checker share mclk and arst_n
`timescale 1ns/10ps
`default_nettype none

module sarrd_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// link pins
	input wire logic conversionStartLine,
	input wire logic selectSerialIn,
	input wire logic serialClock,
	input wire logic serialOut,
	input wire logic serialOutOe,
	input wire logic serialOutLine
);
	logic        startPrev_ff, sclkPrev_ff, selMode_ff, nxt_selMode, startRise, sclkFall;
	logic [10:0] convCnt_ff, nxt_convCnt;
	logic [7:0]  lowCnt_ff, nxt_lowCnt;
	logic [4:0]  fallCnt_ff, nxt_fallCnt;

	// pin history; the conversion and low counts saturate so a long idle never wraps
	always_comb begin
		startRise   = conversionStartLine & ~startPrev_ff;
		sclkFall    = sclkPrev_ff & ~serialClock;
		nxt_selMode = startRise ? selectSerialIn : selMode_ff;
		nxt_convCnt = startRise ? 11'h001 : convCnt_ff + {10'h000, convCnt_ff != 11'h7FF};
		nxt_lowCnt  = conversionStartLine ? 8'h00 : lowCnt_ff + {7'h00, lowCnt_ff != 8'hFF};
		nxt_fallCnt = selectSerialIn ? 5'h00 : fallCnt_ff + {4'h0, sclkFall};
	end

	// registered history
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			startPrev_ff <= 1'b0;
			sclkPrev_ff  <= 1'b0;
			selMode_ff   <= 1'b1;
			convCnt_ff   <= 11'h000;
			lowCnt_ff    <= 8'h00;
			fallCnt_ff   <= 5'h00;
		end else begin
			startPrev_ff <= conversionStartLine;
			sclkPrev_ff  <= serialClock;
			selMode_ff   <= nxt_selMode;
			convCnt_ff   <= nxt_convCnt;
			lowCnt_ff    <= nxt_lowCnt;
			fallCnt_ff   <= nxt_fallCnt;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// 11'h03F = 63 cycles (500 ns), 11'h44C = 1100 cycles (8800 ns), 8'h94 = 148 cycles
	property p_conv_window;
		selMode_ff && serialOutOe && convCnt_ff > 11'h006 |-> convCnt_ff >= 11'h03F;
	endproperty
	a_conv_window: assert property (p_conv_window)
		else $error("output enabled during conversion");
	property p_msb_out;
		selMode_ff && conversionStartLine && convCnt_ff >= 11'h050 && $fell(selectSerialIn)
			|-> ##[2:5] serialOutOe;
	endproperty
	a_msb_out: assert property (p_msb_out)
		else $error("no output after select fell");
	property p_release;
		selMode_ff && $rose(selectSerialIn) |-> ##[1:5] (!serialOutOe && serialOutLine);
	endproperty
	a_release: assert property (p_release)
		else $error("output kept after select rose");
	property p_last_fall;
		selMode_ff && !selectSerialIn && sclkFall && fallCnt_ff == 5'h0F |-> ##[1:5] !serialOutOe;
	endproperty
	a_last_fall: assert property (p_last_fall)
		else $error("output kept after last fall");
	property p_quiet;
		(selMode_ff && selectSerialIn && convCnt_ff >= 11'h008) [*6] |-> !serialOutOe;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("output driven while deselected");
	property p_stable_high;
		serialClock && $past(serialClock) |-> $stable(serialOut);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data moved while clock high");
	property p_low_time;
		$fell(conversionStartLine) |-> !conversionStartLine [*3];
	endproperty
	a_low_time: assert property (p_low_time)
		else $error("start line low too short");
	property p_acq;
		startRise |-> lowCnt_ff >= 8'h94;
	endproperty
	a_acq: assert property (p_acq)
		else $error("acquisition too short");
	property p_wait_read;
		$rose(serialClock) |-> conversionStartLine && convCnt_ff >= 11'h44C;
	endproperty
	a_wait_read: assert property (p_wait_read)
		else $error("read before conversion could end");
	property p_mode_setup;
		startRise |-> !serialClock && $stable(serialClock) && $stable(selectSerialIn);
	endproperty
	a_mode_setup: assert property (p_mode_setup)
		else $error("clock or select moved at start");

	// main scenarios
	c_sel_frame: cover property (selMode_ff && sclkFall && fallCnt_ff == 5'h0F);
	c_daisy_start: cover property (startRise && !selectSerialIn);
	c_sel_start: cover property (startRise && selectSerialIn);
endmodule // sarrd_properties

`default_nettype wire

// [sar_adc_serial_readout_tb.sv]
// bench joining both ends of the readout link, driving the user sides
// assumes package, interface, both ends and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "sarrd_defs.svh"

module sar_adc_serial_readout_tb import sarrd_pkg::*;;
	typedef struct {
		sarrd_word_t p, n;
		logic        dsy;
		sarrd_word_t e;
	} sarrd_row_s;

	logic        mclk       = 1'b0;
	logic        arst_n     = 1'b0;
	logic        runEn      = 1'b0;
	logic        daisySel   = 1'b0;
	logic        outReady   = 1'b0;
	sarrd_word_t posIn      = 16'h0000;
	sarrd_word_t negIn      = 16'h0000;
	logic        converting, inputsConnected, poweredDown, daisyMode, busy, outValid;
	sarrd_word_t lastResult, outData;
	int          nErrors    = 0;
	int          checksDone = 0;
	// ordinary cases: inputs, mode, and the straight binary word they give
	sarrd_row_s  rows [6] = '{
		'{16'h0000, 16'h0000, 1'b0, 16'h0000},
		'{16'hFFFF, 16'h0000, 1'b0, 16'hFFFF},
		'{16'h8000, 16'h0001, 1'b1, 16'h7FFF},
		'{16'h1234, 16'h0034, 1'b0, 16'h1200},
		'{16'hA5A5, 16'h0000, 1'b1, 16'hA5A5},
		'{16'h0001, 16'h0000, 1'b1, 16'h0001}
	};

	sarrd_if lnk ();

	sarrd_adc_end i_sarrd_adc_end (
		.mclk(mclk), .arst_n(arst_n), .lnk(lnk.device),
		.positiveAnalogInput(posIn), .negativeAnalogInput(negIn),
		.converting(converting), .inputsConnected(inputsConnected),
		.poweredDown(poweredDown), .daisyMode(daisyMode), .lastResult(lastResult)
	);
	sarrd_host_end i_sarrd_host_end (
		.mclk(mclk), .arst_n(arst_n), .lnk(lnk.host), .runEn(runEn), .daisySel(daisySel),
		.busy(busy), .outValid(outValid), .outReady(outReady), .outData(outData)
	);
	sarrd_properties i_sarrd_properties (
		.mclk(mclk), .arst_n(arst_n), .conversionStartLine(lnk.conversionStartLine),
		.selectSerialIn(lnk.selectSerialIn), .serialClock(lnk.serialClock),
		.serialOut(lnk.serialOut), .serialOutOe(lnk.serialOutOe),
		.serialOutLine(lnk.serialOutLine)
	);

	// 125 MHz
	always #4 mclk = ~mclk;

	////////////////////////////////////////////////////////////////
	// inputs move 1 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic check(input logic ok, input string what);
		checksDone++;
		if (ok !== 1'b1) begin
			nErrors++;
			$display("Error at %0t ns: %s", $time, what);
		end
	endtask

	// bounded wait, long enough for a full conversion and readout
	task automatic waitFor(ref logic s, input logic lvl);
		int k;
		k = 0;
		while (s !== lvl && k < 2000) begin
			tick(1);
			k++;
		end
		check(s === lvl, "wait ran out");
	endtask

	task automatic getWord(input sarrd_word_t e);
		waitFor(outValid, 1'b1);
		check(outData === e, "wrong result word");
		outReady = 1'b1;
		tick(1);
		outReady = 1'b0;
	endtask

	// one conversion and readout; the next mode is set before this one is read
	task automatic runRow(input sarrd_row_s r, input logic nextDsy);
		int len;
		len = 0;
		posIn = r.p;
		negIn = r.n;
		runEn = 1'b1;
		waitFor(converting, 1'b1);
		check(inputsConnected === 1'b0 && poweredDown === 1'b0, "inputs not cut off");
		while (converting === 1'b1 && len < 2000) begin
			tick(1);
			len++;
		end
		check(len == `SARRD_RES_W * `SARRD_SAR_STEP_CYC, "conversion length");
		check(len * `SARRD_MCLK_NS >= `SARRD_TCONV_MIN_NS
			&& len * `SARRD_MCLK_NS <= `SARRD_TCONV_MAX_NS, "conversion window");
		tick(1);
		check(inputsConnected === 1'b1 && poweredDown === 1'b1, "not acquiring");
		check(lastResult === r.e && daisyMode === r.dsy, "result or mode");
		runEn = 1'b0;
		daisySel = nextDsy;
		getWord(r.e);
		waitFor(busy, 1'b0);
		check(lnk.serialOutLine === 1'b1 || r.dsy, "output not released");
	endtask

	task automatic wrap_up;
		$display("Errors: %0d, checks: %0d", nErrors, checksDone);
		if (nErrors == 0 && checksDone > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		logic seen;
		seen = 1'b0;
		tick(4);
		arst_n = 1'b1;
		tick(1);
		check(lnk.serialOutOe === 1'b0 && busy === 1'b0 && outValid === 1'b0
			&& lastResult === 16'h0000 && poweredDown === 1'b1, "reset values");
		foreach (rows[i]) begin
			runRow(rows[i], rows[(i + 1) % 6].dsy);
		end
		// stalled user: two words fill the buffer, a third conversion must wait
		posIn = 16'h7FFF;
		negIn = 16'h0000;
		runEn = 1'b1;
		repeat (2) begin
			waitFor(converting, 1'b1);
			waitFor(converting, 1'b0);
		end
		repeat (2000) begin
			tick(1);
			seen = seen | converting;
		end
		check(seen === 1'b0 && outValid === 1'b1 && outData === 16'h7FFF, "full buffer");
		runEn = 1'b0;
		outReady = 1'b1;
		tick(1);
		check(outValid === 1'b1 && outData === 16'h7FFF, "second word");
		tick(1);
		check(outValid === 1'b0, "buffer not empty");
		outReady = 1'b0;
		// reset in mid-conversion, then recovery in daisy mode
		runEn = 1'b1;
		waitFor(converting, 1'b1);
		tick(10);
		arst_n = 1'b0;
		runEn = 1'b0;
		daisySel = 1'b1;
		tick(1);
		check(converting === 1'b0 && lnk.conversionStartLine === 1'b0 && lnk.serialClock === 1'b0
			&& lnk.selectSerialIn === 1'b1 && lastResult === 16'h0000, "mid-run reset");
		tick(3);
		arst_n = 1'b1;
		runRow(rows[4], 1'b0);
		wrap_up();
	end

	// watchdog: nearly three times the expected run
	initial begin
		repeat (40000) @(posedge mclk);
		nErrors++;
		$display("Error at %0t ns: run did not finish", $time);
		wrap_up();
	end
endmodule // sar_adc_serial_readout_tb

`default_nettype wire
